// file: core/rgc_pkg.sv
package rgc_pkg;

    // Clock and dwell timing
    localparam int CLK_PERIOD_NS   = 20;
    localparam int DWELL_REF_NS    = 25000;
    localparam int DWELL_REF_DIV   = 40;
    localparam int TICK_CYCLES     = DWELL_REF_NS / (CLK_PERIOD_NS * DWELL_REF_DIV);
    localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);

    // Register indexes; byte address is four times the index
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_RADIO_CFG7  = 10'h113;
    localparam logic [9:0] IDX_STRENGTH    = 10'h312;
    localparam logic [9:0] IDX_CONV_A      = 10'h327;
    localparam logic [9:0] IDX_CONV_B      = 10'h328;
    localparam logic [9:0] IDX_DWELL_DIV   = 10'h32F;
    localparam logic [9:0] IDX_MODE_CTL    = 10'h35D;
    localparam logic [9:0] IDX_LOW_THR     = 10'h35E;
    localparam logic [9:0] IDX_HIGH_THR    = 10'h35F;
    localparam logic [9:0] IDX_GAIN_STATUS = 10'h360;

    // Reset values
    localparam logic [7:0] RST_RADIO_CFG7 = 8'h00;
    localparam logic [7:0] RST_DWELL_DIV  = 8'h28;
    localparam logic [7:0] RST_MODE_CTL   = 8'h00;
    localparam logic [7:0] RST_LOW_THR    = 8'h30;
    localparam logic [7:0] RST_HIGH_THR   = 8'hC0;

    // Field positions
    localparam int LOCK_LSB  = 0;
    localparam int HOLD_BIT  = 6;
    localparam int MODE_LSB  = 0;

    // Gain modes and converter
    localparam logic [2:0] MODE_MIN   = 3'h1;
    localparam logic [2:0] MODE_MAX   = 3'h6;
    localparam logic [1:0] SAR_SETTLE = 2'h3;
    localparam int         AVG_SHIFT  = 3;
    localparam logic [2:0] AVG_LAST   = 3'h7;
    localparam logic signed [7:0] STRENGTH_OFFSET = 8'sh02;

    typedef enum logic [1:0] {
        LOCK_FREE     = 2'b00,
        LOCK_MANUAL   = 2'b01,
        LOCK_HOLD     = 2'b10,
        LOCK_PREAMBLE = 2'b11
    } rgc_lock_t;

    typedef enum logic [1:0] {
        CMD_IDLE  = 2'b00,
        CMD_ACCUM = 2'b01,
        CMD_LOAD  = 2'b10
    } rgc_cmd_t;

    function automatic logic [7:0] gain_code(input logic [2:0] m);
        case (m)
            3'h1:    gain_code = 8'h00;
            3'h2:    gain_code = 8'h01;
            3'h3:    gain_code = 8'h02;
            3'h4:    gain_code = 8'h0A;
            3'h5:    gain_code = 8'h12;
            default: gain_code = 8'h16;
        endcase
    endfunction

    // LNA: 2 high, 1 medium, 0 low
    function automatic logic [1:0] lna_of(input logic [2:0] m);
        lna_of = (m <= 3'h2) ? 2'h2 : ((m == 3'h3) ? 2'h1 : 2'h0);
    endfunction

    // Mixer: 1 high, 0 low
    function automatic logic mix_of(input logic [2:0] m);
        mix_of = (m == 3'h1);
    endfunction

    // Filter: 2 high, 1 medium, 0 low
    function automatic logic [1:0] filt_of(input logic [2:0] m);
        filt_of = (m <= 3'h4) ? 2'h2 : ((m == 3'h5) ? 2'h1 : 2'h0);
    endfunction

    function automatic logic [7:0] correction(input logic [2:0] m);
        case (m)
            3'h1:    correction = 8'h2C;
            3'h2:    correction = 8'h23;
            3'h3:    correction = 8'h1A;
            3'h4:    correction = 8'h11;
            3'h5:    correction = 8'h0A;
            default: correction = 8'h00;
        endcase
    endfunction

    // Two's complement strength: dBm plus 107
    function automatic logic [7:0] strength(input logic [7:0] res, input logic [2:0] m);
        strength = 8'(res / 8'h07) + correction(m) - STRENGTH_OFFSET;
    endfunction

    function automatic logic [2:0] clamp_mode(input logic [2:0] m);
        if (m < MODE_MIN) begin
            clamp_mode = MODE_MIN;
        end else if (m > MODE_MAX) begin
            clamp_mode = MODE_MAX;
        end else begin
            clamp_mode = m;
        end
    endfunction

endpackage

// file: core/rgc_sar.sv
`timescale 1ns/10ps
module rgc_sar (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cmp_above,
    output logic [7:0]      dac_q,
    output logic [7:0]      result_q,
    output logic            done_q
);
    import rgc_pkg::*;

    logic [2:0] bit_q, bit_d;
    logic [1:0] wait_q, wait_d;
    logic [7:0] dac_d, result_d, kept;
    logic       done_d;

    // Successive approximation, MSB first, one settle wait per bit
    always_comb begin
        bit_d    = bit_q;
        wait_d   = wait_q + 2'h1;
        dac_d    = dac_q;
        result_d = result_q;
        done_d   = 1'b0;
        kept     = cmp_above ? dac_q : (dac_q & ~(8'h01 << bit_q));
        if (wait_q == SAR_SETTLE) begin
            wait_d = 2'h0;
            if (bit_q == 3'h0) begin
                result_d = kept;
                done_d   = 1'b1;
                dac_d    = 8'h80;
                bit_d    = 3'h7;
            end else begin
                dac_d = kept | (8'h01 << (bit_q - 3'h1));
                bit_d = bit_q - 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bit_q    <= 3'h7;
            wait_q   <= 2'h0;
            dac_q    <= 8'h80;
            result_q <= 8'h00;
            done_q   <= 1'b0;
        end else begin
            bit_q    <= bit_d;
            wait_q   <= wait_d;
            dac_q    <= dac_d;
            result_q <= result_d;
            done_q   <= done_d;
        end
    end

endmodule

// file: core/rgc_gain_control.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
// Function
// - Controller active by default after reset
// - Six gain modes per the gain table
// - LNA three, mixer two, filter three levels
// - Dwell per mode set by divider, default 0x28
// - Strength above high threshold lowers gain
// - Strength below low threshold raises gain
// - Lock field: free, manual, hold, preamble lock
// - Applied gains readable in gain status
// - 8-bit SAR result feeds readback and controller
// - Packet end stores postamble strength, two's complement
// - End-of-packet capture only in packet mode
// - Get command only from idle-on, filtered result
module rgc_gain_control (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [rgc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     receive_state,
    input  wire logic                     idle_on_state,
    input  wire logic                     packet_mode,
    input  wire logic                     preamble_detected,
    input  wire logic                     packet_end,
    input  wire logic                     get_signal_strength_command,
    input  wire logic                     sar_cmp_pin,
    output logic [7:0]                    sar_dac,
    output logic [1:0]                    lna_gain,
    output logic                          mixer_gain,
    output logic [1:0]                    filter_gain
);
    import rgc_pkg::*;

    logic [7:0]  cfg7_q, cfg7_d, div_q, div_d, ctl_q, ctl_d;
    logic [7:0]  low_q, low_d, high_q, high_d, rssi_q, rssi_d, snap_q, snap_d;
    logic [31:0] rdata_d;
    logic        rdy_d, err_d, wr_en, hit;
    logic [9:0]  idx;
    logic [2:0]  mode_q, mode_d;
    logic [4:0]  pre_q, pre_d;
    logic [7:0]  dwell_q, dwell_d, dwell_last;
    logic        unit_tick, dwell_tick, run, frozen, lock_q, lock_d;
    logic [1:0]  cmp_sync_q;
    logic [7:0]  conv;
    logic        conv_done;
    rgc_cmd_t    cmd_q, cmd_d;
    logic [10:0] acc_q, acc_d;
    logic [2:0]  cnt_q, cnt_d;
    rgc_lock_t   lock_mode;

    assign lock_mode  = rgc_lock_t'(cfg7_q[LOCK_LSB +: 2]);
    assign idx        = paddr[11:2];
    assign wr_en      = psel && penable && pready && pwrite && !pslverr;

    rgc_sar u_sar (
        .clk       (clk),
        .rst       (rst),
        .cmp_above (cmp_sync_q[1]),
        .dac_q     (sar_dac),
        .result_q  (conv),
        .done_q    (conv_done)
    );

    // Register bus: zero wait state, read data prepared in the setup cycle
    always_comb begin
        hit = 1'b1;
        case (idx)
            IDX_RADIO_CFG7:  rdata_d = {24'h00_0000, cfg7_q};
            IDX_STRENGTH:    rdata_d = {24'h00_0000, rssi_q};
            IDX_CONV_A:      rdata_d = {28'h000_0000, conv[3:0]};
            IDX_CONV_B:      rdata_d = {28'h000_0000, snap_q[7:4]};
            IDX_DWELL_DIV:   rdata_d = {24'h00_0000, div_q};
            IDX_MODE_CTL:    rdata_d = {24'h00_0000, ctl_q};
            IDX_LOW_THR:     rdata_d = {24'h00_0000, low_q};
            IDX_HIGH_THR:    rdata_d = {24'h00_0000, high_q};
            IDX_GAIN_STATUS: rdata_d = {24'h00_0000, gain_code(mode_q)};
            default: begin
                rdata_d = 32'h0000_0000;
                hit     = 1'b0;
            end
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
        if (!(psel && !penable)) begin
            rdata_d = prdata;
        end
        rdy_d = psel && !penable;
        err_d = psel && !penable && !hit;
    end

    always_comb begin
        cfg7_d = cfg7_q;
        div_d  = div_q;
        ctl_d  = ctl_q;
        low_d  = low_q;
        high_d = high_q;
        snap_d = snap_q;
        if (psel && !penable && !pwrite && idx == IDX_CONV_A) begin
            snap_d = conv; // Upper half frozen so the pair reads coherent
        end
        if (wr_en) begin
            case (idx)
                IDX_RADIO_CFG7: cfg7_d = pwdata[7:0];
                IDX_DWELL_DIV:  div_d  = pwdata[7:0];
                IDX_MODE_CTL:   ctl_d  = pwdata[7:0];
                IDX_LOW_THR:    low_d  = pwdata[7:0];
                IDX_HIGH_THR:   high_d = pwdata[7:0];
                default:        cfg7_d = cfg7_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            cfg7_q  <= RST_RADIO_CFG7;
            div_q   <= RST_DWELL_DIV;
            ctl_q   <= RST_MODE_CTL;
            low_q   <= RST_LOW_THR;
            high_q  <= RST_HIGH_THR;
            snap_q  <= 8'h00;
        end else begin
            prdata  <= rdata_d;
            pready  <= rdy_d;
            pslverr <= err_d;
            cfg7_q  <= cfg7_d;
            div_q   <= div_d;
            ctl_q   <= ctl_d;
            low_q   <= low_d;
            high_q  <= high_d;
            snap_q  <= snap_d;
        end
    end

    // Dwell timing: prescaled unit, then divider count; zero acts as one
    assign dwell_last = (div_q == 8'h00) ? 8'h01 : div_q;
    assign unit_tick  = (pre_q == TICK_LAST);
    assign dwell_tick = unit_tick && (dwell_q + 8'h01 == dwell_last);
    assign frozen     = ctl_q[HOLD_BIT] || lock_mode == LOCK_HOLD || lock_q;
    assign run        = receive_state && lock_mode != LOCK_MANUAL && !frozen;

    always_comb begin
        pre_d   = 5'h00;
        dwell_d = 8'h00;
        if (run) begin
            pre_d   = unit_tick ? 5'h00 : pre_q + 5'h01;
            dwell_d = dwell_q;
            if (unit_tick) begin
                dwell_d = dwell_tick ? 8'h00 : dwell_q + 8'h01;
            end
        end
        // Preamble lock holds until the receive state ends; set wins
        lock_d = lock_q && receive_state;
        if (lock_mode == LOCK_PREAMBLE && receive_state && preamble_detected) begin
            lock_d = 1'b1;
        end
        if (lock_mode != LOCK_PREAMBLE) begin
            lock_d = 1'b0;
        end
        mode_d = mode_q;
        if (lock_mode == LOCK_MANUAL) begin
            mode_d = clamp_mode(ctl_q[MODE_LSB +: 3]);
        end else if (run && dwell_tick) begin
            if (conv > high_q && mode_q < MODE_MAX) begin
                mode_d = mode_q + 3'h1;
            end else if (conv < low_q && mode_q > MODE_MIN) begin
                mode_d = mode_q - 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q       <= 5'h00;
            dwell_q     <= 8'h00;
            lock_q      <= 1'b0;
            mode_q      <= MODE_MIN;
            lna_gain    <= 2'h2;
            mixer_gain  <= 1'b1;
            filter_gain <= 2'h2;
            cmp_sync_q  <= 2'h0;
        end else begin
            pre_q       <= pre_d;
            dwell_q     <= dwell_d;
            lock_q      <= lock_d;
            mode_q      <= mode_d;
            lna_gain    <= lna_of(mode_d);
            mixer_gain  <= mix_of(mode_d);
            filter_gain <= filt_of(mode_d);
            cmp_sync_q  <= {cmp_sync_q[0], sar_cmp_pin};
        end
    end

    // Strength capture: packet end, or averaged get command
    always_comb begin
        cmd_d  = cmd_q;
        acc_d  = acc_q;
        cnt_d  = cnt_q;
        rssi_d = rssi_q;
        case (cmd_q)
            CMD_IDLE: begin
                if (get_signal_strength_command && idle_on_state) begin
                    cmd_d = CMD_ACCUM;
                    acc_d = 11'h000;
                    cnt_d = 3'h0;
                end else if (packet_end && packet_mode) begin
                    rssi_d = strength(conv, mode_q);
                end
            end
            CMD_ACCUM: begin
                if (conv_done) begin
                    acc_d = acc_q + {3'h0, conv};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == AVG_LAST) begin
                        cmd_d = CMD_LOAD;
                    end
                end
            end
            CMD_LOAD: begin
                rssi_d = strength(8'(acc_q >> AVG_SHIFT), mode_q);
                cmd_d  = CMD_IDLE;
            end
            default: cmd_d = CMD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_q  <= CMD_IDLE;
            acc_q  <= 11'h000;
            cnt_q  <= 3'h0;
            rssi_q <= 8'h00;
        end else begin
            cmd_q  <= cmd_d;
            acc_q  <= acc_d;
            cnt_q  <= cnt_d;
            rssi_q <= rssi_d;
        end
    end

    a_mode_range: assert property (@(posedge clk) disable iff (rst)
        mode_q >= MODE_MIN && mode_q <= MODE_MAX) else $error("gain mode out of range");
    a_pins_match: assert property (@(posedge clk) disable iff (rst)
        lna_gain == lna_of(mode_q) && mixer_gain == mix_of(mode_q) && filter_gain == filt_of(mode_q))
        else $error("gain pins disagree with mode");
    a_reset_default: assert property (@(posedge clk) rst |=>
        lock_mode == LOCK_FREE && mode_q == MODE_MIN && div_q == RST_DWELL_DIV)
        else $error("reset state wrong");
    a_step_down: assert property (@(posedge clk) disable iff (rst)
        run && dwell_tick && conv > high_q && mode_q < MODE_MAX |=> mode_q == $past(mode_q) + 3'h1)
        else $error("gain not reduced");
    a_step_up: assert property (@(posedge clk) disable iff (rst)
        run && dwell_tick && conv < low_q && conv <= high_q && mode_q > MODE_MIN
        |=> mode_q == $past(mode_q) - 3'h1) else $error("gain not raised");
    a_one_step: assert property (@(posedge clk) disable iff (rst)
        lock_mode != LOCK_MANUAL && $changed(mode_q) |->
        (mode_q == $past(mode_q) + 3'h1 || mode_q == $past(mode_q) - 3'h1) && $past(dwell_tick))
        else $error("gain moved without dwell or by more than one");
    a_dwell_min: assert property (@(posedge clk) disable iff (rst)
        dwell_tick |=> !dwell_tick [*2]) else $error("dwell ticks too close");
    a_hold_stable: assert property (@(posedge clk) disable iff (rst)
        lock_mode == LOCK_HOLD && $past(lock_mode) == LOCK_HOLD |-> $stable(mode_q))
        else $error("gain moved while held");
    a_manual_follow: assert property (@(posedge clk) disable iff (rst)
        lock_mode == LOCK_MANUAL |=> mode_q == clamp_mode($past(ctl_q[MODE_LSB +: 3])))
        else $error("manual gain not applied");
    a_status_read: assert property (@(posedge clk) disable iff (rst)
        psel && !penable && paddr == {IDX_GAIN_STATUS, 2'h0} |=> prdata[7:0] == gain_code($past(mode_q)))
        else $error("gain status read wrong");
    a_packet_capture: assert property (@(posedge clk) disable iff (rst)
        cmd_q == CMD_IDLE && packet_end && packet_mode && !get_signal_strength_command
        |=> rssi_q == strength($past(conv), $past(mode_q))) else $error("packet strength not stored");
    a_no_sport: assert property (@(posedge clk) disable iff (rst)
        cmd_q == CMD_IDLE && !packet_mode && !get_signal_strength_command |=> $stable(rssi_q))
        else $error("strength stored outside packet mode");
    a_cmd_idle_only: assert property (@(posedge clk) disable iff (rst)
        cmd_q == CMD_IDLE && get_signal_strength_command && !idle_on_state |=> cmd_q == CMD_IDLE)
        else $error("get command accepted outside idle-on");
    a_apb_ready: assert property (@(posedge clk) disable iff (rst)
        psel && !penable |=> pready ##1 !pready) else $error("ready not one cycle after setup");

    c_reduce: cover property (@(posedge clk) disable iff (rst) mode_q == MODE_MAX);
    c_get_cmd: cover property (@(posedge clk) disable iff (rst) cmd_q == CMD_LOAD);
    c_preamble_lock: cover property (@(posedge clk) disable iff (rst) lock_q && receive_state);

endmodule

// file: testbench/rgc_analog_model.sv
`timescale 1ns/10ps
module rgc_analog_model (
    input  wire logic [7:0] sar_dac,
    input  wire logic [7:0] level,
    output logic            sar_cmp_pin
);
    // Comparator of the strength converter: high while the analog level reaches the trial value
    assign sar_cmp_pin = (level >= sar_dac);
endmodule

// file: testbench/rgc_gain_control_tb.sv
`timescale 1ns/10ps
module rgc_gain_control_tb;
    import rgc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_on = 1'b0;
    logic        idle_on = 1'b0;
    logic        pkt_mode = 1'b0;
    logic        preamble = 1'b0;
    logic        pkt_end = 1'b0;
    logic        get_cmd = 1'b0;
    logic        cmp_pin;
    logic [7:0]  dac;
    logic [7:0]  level = 8'h80;
    logic [1:0]  lna;
    logic        mixer;
    logic [1:0]  filt;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [31:0] rdat;
    logic        rerr;
    // Manual table: mode, lna, mixer, filter, status code
    logic [15:0] rows [6] = '{16'h3600, 16'h5201, 16'h6A02, 16'h820A, 16'hA112, 16'hC016};
    logic [17:0] rst_rows [7];

    always #10 clk = ~clk;

    rgc_gain_control u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receive_state(rx_on), .idle_on_state(idle_on), .packet_mode(pkt_mode),
        .preamble_detected(preamble), .packet_end(pkt_end), .get_signal_strength_command(get_cmd),
        .sar_cmp_pin(cmp_pin), .sar_dac(dac), .lna_gain(lna), .mixer_gain(mixer), .filter_gain(filt)
    );

    rgc_analog_model u_analog (.sar_dac(dac), .level(level), .sar_cmp_pin(cmp_pin));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // A hung access is ended by the cycle ceiling, not here
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(name, {24'h00_0000, exp}, rdat);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        rx_on <= 1'b0;
        wait_cyc(10);
        rst <= 1'b0;
    endtask

    // Host view: correction from the status code, then result/7 + correction, offset to dBm + 107
    function automatic logic [7:0] exp_str(input int lvl, input logic [7:0] status);
        int corr;
        case (status)
            8'h00:   corr = 44;
            8'h01:   corr = 35;
            8'h02:   corr = 26;
            8'h0A:   corr = 17;
            8'h12:   corr = 10;
            default: corr = 0;
        endcase
        return 8'(lvl / 7 + corr - 2);
    endfunction

    initial begin
        rst_rows = '{{IDX_RADIO_CFG7, 8'h00}, {IDX_DWELL_DIV, 8'h28}, {IDX_MODE_CTL, 8'h00},
                     {IDX_LOW_THR, 8'h30}, {IDX_HIGH_THR, 8'hC0}, {IDX_GAIN_STATUS, 8'h00},
                     {IDX_STRENGTH, 8'h00}};
        do_reset();
        foreach (rst_rows[i]) begin
            rd_chk("reset value", rst_rows[i][17:8], rst_rows[i][7:0]);
        end
        chk("mode 1 pins", 32'h0000_0016, {27'h0, lna, mixer, filt});
        apb(1'b0, 10'h000, 8'h00);
        chk("unmapped error", 32'h0000_0001, {31'h0, rerr});
        chk("unmapped data", 32'h0000_0000, rdat);
        apb(1'b1, IDX_GAIN_STATUS, 8'hFF);
        rd_chk("status read only", IDX_GAIN_STATUS, 8'h00);
        // Strength capture paths, gain stays in mode 1 outside receive
        level <= 8'h70;
        idle_on <= 1'b1;
        wait_cyc(100);
        @(posedge clk) get_cmd <= 1'b1;
        @(posedge clk) get_cmd <= 1'b0;
        wait_cyc(450);
        rd_chk("command strength", IDX_STRENGTH, exp_str(8'h70, 8'h00));
        idle_on <= 1'b0;
        level <= 8'h8C;
        wait_cyc(100);
        @(posedge clk) get_cmd <= 1'b1;
        @(posedge clk) get_cmd <= 1'b0;
        wait_cyc(450);
        rd_chk("command outside idle", IDX_STRENGTH, exp_str(8'h70, 8'h00));
        @(posedge clk) pkt_end <= 1'b1;
        @(posedge clk) pkt_end <= 1'b0;
        wait_cyc(5);
        rd_chk("sport mode capture", IDX_STRENGTH, exp_str(8'h70, 8'h00));
        pkt_mode <= 1'b1;
        @(posedge clk) pkt_end <= 1'b1;
        @(posedge clk) pkt_end <= 1'b0;
        wait_cyc(5);
        rd_chk("packet end strength", IDX_STRENGTH, exp_str(8'h8C, 8'h00));
        rd_chk("converter low", IDX_CONV_A, 8'h0C);
        rd_chk("converter high", IDX_CONV_B, 8'h08);
        // Manual gains through every mode
        apb(1'b1, IDX_RADIO_CFG7, 8'h01);
        foreach (rows[i]) begin
            apb(1'b1, IDX_MODE_CTL, {5'h00, rows[i][15:13]});
            wait_cyc(4);
            chk("manual pins", {27'h0, rows[i][12:8]}, {27'h0, lna, mixer, filt});
            rd_chk("manual status", IDX_GAIN_STATUS, rows[i][7:0]);
        end
        // Automatic stepping with a short dwell
        do_reset();
        apb(1'b1, IDX_DWELL_DIV, 8'h02);
        level <= 8'hF0;
        wait_cyc(100);
        rx_on <= 1'b1;
        wait_cyc(50);
        rd_chk("before first dwell", IDX_GAIN_STATUS, 8'h00);
        wait_cyc(10);
        rd_chk("after first dwell", IDX_GAIN_STATUS, 8'h01);
        wait_cyc(400);
        rd_chk("lowest gain", IDX_GAIN_STATUS, 8'h16);
        chk("mode 6 pins", 32'h0000_0000, {27'h0, lna, mixer, filt});
        level <= 8'h10;
        wait_cyc(450);
        rd_chk("highest gain", IDX_GAIN_STATUS, 8'h00);
        level <= 8'h80;
        wait_cyc(100);
        // Hold, freeze and preamble lock keep the gain while the level is high
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, (k == 1) ? IDX_MODE_CTL : IDX_RADIO_CFG7, (k == 0) ? 8'h02 : ((k == 1) ? 8'h40 : 8'h03));
            level <= 8'hF0;
            @(posedge clk) preamble <= 1'b1;
            @(posedge clk) preamble <= 1'b0;
            wait_cyc(300);
            rd_chk("frozen status", IDX_GAIN_STATUS, 8'h00);
            rd_chk("frozen converter low", IDX_CONV_A, 8'h00);
            rd_chk("frozen converter high", IDX_CONV_B, 8'h0F);
            level <= 8'h80;
            wait_cyc(100);
            apb(1'b1, (k == 1) ? IDX_MODE_CTL : IDX_RADIO_CFG7, 8'h00);
        end
        report_and_stop();
    end
endmodule
